//--- inc/aro_defs.vh
`ifndef ARO_DEFS_VH
`define ARO_DEFS_VH

// Register byte offsets (low 12 address bits)
`define ARO_OFF_INSTR  12'h000
`define ARO_OFF_ACC    12'h004
`define ARO_OFF_STAT   12'h008
`define ARO_OFF_PTR0   12'h00c
`define ARO_OFF_PTR1   12'h010
`define ARO_OFF_PC     12'h014
`define ARO_OFF_INTC   12'h018
`define ARO_OFF_STACK  12'h01c
// Data file window: 128 words from 0x200 to 0x3fc
`define ARO_FILE_TAG   3'b001

// Instruction word fields
`define ARO_F_OP_HI    23
`define ARO_F_OP_LO    20
`define ARO_F_PSEL     16
`define ARO_F_DEST     15
`define ARO_F_FA_HI    14
`define ARO_F_FA_LO    8
`define ARO_F_LIT_HI   7
`define ARO_F_LIT_LO   0
`define ARO_F_OFF_HI   5

// Operation codes
`define ARO_OP_PTRADD  4'h0
`define ARO_OP_ANDLIT  4'h1
`define ARO_OP_ADDLIT  4'h2
`define ARO_OP_ANDF    4'h3
`define ARO_OP_ADDF    4'h4
`define ARO_OP_ASR     4'h5
`define ARO_OP_ADDCF   4'h6
`define ARO_OP_RLC     4'h7
`define ARO_OP_RETI    4'h8
`define ARO_OP_RET     4'h9
`define ARO_OP_RETLIT  4'ha

// Status and control bit positions
`define ARO_ST_C       0
`define ARO_ST_DC      1
`define ARO_ST_Z       2
`define ARO_ST_BUSY    7
`define ARO_INTC_GATE  7

// Reset values
`define ARO_RST_BYTE   8'h00
`define ARO_RST_PTR    16'h0000
`define ARO_RST_PC     15'h0000
`define ARO_RST_SP     4'h0

`endif

//--- logic/aro_core.v
`timescale 1ns/1ps
`include "aro_defs.vh"
`default_nettype none

module aro_core (
	input  wire        core_clk,
	input  wire        rst,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output wire        hreadyout,
	output reg  [31:0] hrdata,
	output wire        hresp
);

	localparam [1:0] ST_IDLE = 2'd0;
	localparam [1:0] ST_EXEC = 2'd1;
	localparam [1:0] ST_RET  = 2'd2;

	reg        wrPend_q;
	reg        rdPend_q;
	reg [11:0] addr_q;
	reg [1:0]  state_q;
	reg [23:0] instr_q;
	reg [7:0]  acc_q;
	reg        flagC_q;
	reg        flagDc_q;
	reg        flagZ_q;
	reg [15:0] ptr0_q;
	reg [15:0] ptr1_q;
	reg [14:0] pc_q;
	reg [7:0]  intc_q;
	reg [3:0]  sp_q;
	reg [14:0] retAddr_q;
	reg [7:0]  fileMem [0:127];
	reg [14:0] stackMem [0:15];

	////////////////////////////////////////////////////////////////////
	// AHB-Lite slave front end

	wire addrPhase;
	wire busWr;
	wire fileHit;
	wire [6:0] fileIdx;

	// Only whole-word singles are expected, so hsize is not decoded
	assign addrPhase = hsel & htrans[1] & hready;
	assign busWr     = wrPend_q;
	assign fileHit   = (addr_q[11:9] == `ARO_FILE_TAG);
	assign fileIdx   = addr_q[8:2];
	// Reads take one wait state so a write just before is seen
	assign hreadyout = ~rdPend_q;
	assign hresp     = 1'b0;

	// Address phase capture
	always @(posedge core_clk) begin
		if (rst) begin
			wrPend_q <= 1'b0;
			rdPend_q <= 1'b0;
			addr_q   <= 12'h000;
		end else begin
			wrPend_q <= addrPhase & hwrite;
			rdPend_q <= addrPhase & ~hwrite;
			if (addrPhase) begin
				addr_q <= haddr[11:0];
			end
		end
	end

	wire selInstr;
	wire selAcc;
	wire selStat;
	wire selPtr0;
	wire selPtr1;
	wire selPc;
	wire selIntc;
	wire selStack;
	wire idle;

	// Write strobes in the data phase
	assign idle     = (state_q == ST_IDLE);
	assign selInstr = busWr & (addr_q == `ARO_OFF_INSTR);
	assign selAcc   = busWr & (addr_q == `ARO_OFF_ACC);
	assign selStat  = busWr & (addr_q == `ARO_OFF_STAT);
	assign selPtr0  = busWr & (addr_q == `ARO_OFF_PTR0);
	assign selPtr1  = busWr & (addr_q == `ARO_OFF_PTR1);
	assign selPc    = busWr & (addr_q == `ARO_OFF_PC);
	assign selIntc  = busWr & (addr_q == `ARO_OFF_INTC);
	assign selStack = busWr & (addr_q == `ARO_OFF_STACK);

	////////////////////////////////////////////////////////////////////
	// Instruction decode and datapath

	wire [3:0]  op;
	wire [7:0]  lit;
	wire [6:0]  fa;
	wire        dest;
	wire        psel;
	wire [5:0]  off6;
	wire [7:0]  fv;
	wire        exec;
	wire [15:0] ptrCur;
	wire [14:0] stackHead;

	assign op     = instr_q[`ARO_F_OP_HI:`ARO_F_OP_LO];
	assign lit    = instr_q[`ARO_F_LIT_HI:`ARO_F_LIT_LO];
	assign fa     = instr_q[`ARO_F_FA_HI:`ARO_F_FA_LO];
	assign dest   = instr_q[`ARO_F_DEST];
	assign psel   = instr_q[`ARO_F_PSEL];
	assign off6   = instr_q[`ARO_F_OFF_HI:`ARO_F_LIT_LO];
	assign fv     = fileMem[fa];
	assign exec   = (state_q == ST_EXEC);
	assign ptrCur = psel ? ptr1_q : ptr0_q;
	// Empty stack pops wrap to the last slot, as a circular stack does
	assign stackHead = stackMem[sp_q - 4'h1];

	reg [7:0]  opB;
	reg        cIn;
	reg [8:0]  sum9;
	reg [4:0]  nib5;
	reg [7:0]  res;
	reg        cOut;
	reg        updC;
	reg        updDc;
	reg        updZ;
	reg        toAcc;
	reg        toFile;
	reg        ptrWr;
	reg [15:0] ptrNext;

	// Combinational ALU for the single-cycle group
	always @* begin
		opB     = (op == `ARO_OP_ADDLIT) ? lit : fv;
		cIn     = (op == `ARO_OP_ADDCF) ? flagC_q : 1'b0;
		sum9    = {1'b0, acc_q} + {1'b0, opB} + {8'h00, cIn};
		nib5    = {1'b0, acc_q[3:0]} + {1'b0, opB[3:0]} + {4'h0, cIn};
		ptrNext = ptrCur + {{10{off6[5]}}, off6};
		res     = 8'h00;
		cOut    = flagC_q;
		updC    = 1'b0;
		updDc   = 1'b0;
		updZ    = 1'b0;
		toAcc   = 1'b0;
		toFile  = 1'b0;
		ptrWr   = 1'b0;
		case (op)
			`ARO_OP_PTRADD: begin
				ptrWr = 1'b1;
			end
			`ARO_OP_ANDLIT: begin
				res   = acc_q & lit;
				updZ  = 1'b1;
				toAcc = 1'b1;
			end
			`ARO_OP_ADDLIT: begin
				res   = sum9[7:0];
				cOut  = sum9[8];
				updC  = 1'b1;
				updDc = 1'b1;
				updZ  = 1'b1;
				toAcc = 1'b1;
			end
			`ARO_OP_ANDF: begin
				res  = acc_q & fv;
				updZ = 1'b1;
			end
			`ARO_OP_ADDF, `ARO_OP_ADDCF: begin
				res   = sum9[7:0];
				cOut  = sum9[8];
				updC  = 1'b1;
				updDc = 1'b1;
				updZ  = 1'b1;
			end
			// Sign bit kept, bit 0 to carry
			`ARO_OP_ASR: begin
				res  = {fv[7], fv[7:1]};
				cOut = fv[0];
				updC = 1'b1;
				updZ = 1'b1;
			end
			`ARO_OP_RLC: begin
				res  = {fv[6:0], flagC_q};
				cOut = fv[7];
				updC = 1'b1;
			end
			default: begin
				res = 8'h00;
			end
		endcase
		if ((op == `ARO_OP_ANDF) || (op == `ARO_OP_ADDF) ||
			(op == `ARO_OP_ASR) || (op == `ARO_OP_ADDCF) ||
			(op == `ARO_OP_RLC)) begin
			toAcc  = ~dest;
			toFile = dest;
		end
	end

	wire isRet;
	assign isRet = (op == `ARO_OP_RETI) || (op == `ARO_OP_RET) ||
		(op == `ARO_OP_RETLIT);

	////////////////////////////////////////////////////////////////////
	// Sequencer: one cycle for ALU work, two for returns

	// Instruction writes while busy are dropped
	always @(posedge core_clk) begin
		if (rst) begin
			state_q <= ST_IDLE;
			instr_q <= 24'h000000;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (selInstr) begin
						instr_q <= hwdata[23:0];
						state_q <= ST_EXEC;
					end
				end
				ST_EXEC: begin
					state_q <= isRet ? ST_RET : ST_IDLE;
				end
				ST_RET: begin
					state_q <= ST_IDLE;
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Architectural state; execution wins over a bus write

	// Accumulator
	always @(posedge core_clk) begin
		if (rst) begin
			acc_q <= `ARO_RST_BYTE;
		end else if (exec && toAcc) begin
			acc_q <= res;
		// Literal loaded on the pop cycle
		end else if (exec && (op == `ARO_OP_RETLIT)) begin
			acc_q <= lit;
		end else if (selAcc) begin
			acc_q <= hwdata[7:0];
		end
	end

	// Status flags; returns and pointer add leave them alone
	always @(posedge core_clk) begin
		if (rst) begin
			flagC_q  <= 1'b0;
			flagDc_q <= 1'b0;
			flagZ_q  <= 1'b0;
		end else if (exec) begin
			if (updC) begin
				flagC_q <= cOut;
			end
			// Carry out of bit 3, zero test
			if (updDc) begin
				flagDc_q <= nib5[4];
			end
			if (updZ) begin
				flagZ_q <= (res == 8'h00);
			end
		end else if (selStat) begin
			flagC_q  <= hwdata[`ARO_ST_C];
			flagDc_q <= hwdata[`ARO_ST_DC];
			flagZ_q  <= hwdata[`ARO_ST_Z];
		end
	end

	// Pointer pairs
	always @(posedge core_clk) begin
		if (rst) begin
			ptr0_q <= `ARO_RST_PTR;
			ptr1_q <= `ARO_RST_PTR;
		end else begin
			if (exec && ptrWr && !psel) begin
				ptr0_q <= ptrNext;
			end else if (selPtr0) begin
				ptr0_q <= hwdata[15:0];
			end
			if (exec && ptrWr && psel) begin
				ptr1_q <= ptrNext;
			end else if (selPtr1) begin
				ptr1_q <= hwdata[15:0];
			end
		end
	end

	// Data file
	always @(posedge core_clk) begin
		if (exec && toFile) begin
			fileMem[fa] <= res;
		end else if (busWr && fileHit) begin
			fileMem[fileIdx] <= hwdata[7:0];
		end
	end

	// Return stack: pushed by software, popped by returns
	always @(posedge core_clk) begin
		if (rst) begin
			sp_q      <= `ARO_RST_SP;
			retAddr_q <= `ARO_RST_PC;
		end else if (exec && isRet) begin
			sp_q      <= sp_q - 4'h1;
			retAddr_q <= stackHead;
		end else if (selStack && idle) begin
			stackMem[sp_q] <= hwdata[14:0];
			sp_q           <= sp_q + 4'h1;
		end
	end

	// Program counter and interrupt control
	always @(posedge core_clk) begin
		if (rst) begin
			pc_q   <= `ARO_RST_PC;
			intc_q <= `ARO_RST_BYTE;
		end else begin
			// Popped address lands on second cycle
			if (state_q == ST_RET) begin
				pc_q <= retAddr_q;
			end else if (selPc) begin
				pc_q <= hwdata[14:0];
			end
			// Gate set with the PC load
			if ((state_q == ST_RET) && (op == `ARO_OP_RETI)) begin
				intc_q[`ARO_INTC_GATE] <= 1'b1;
			end else if (selIntc) begin
				intc_q <= hwdata[7:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Read path, registered in the wait cycle

	reg [31:0] rdMux;

	// Unmapped addresses read as zero
	always @* begin
		rdMux = 32'h00000000;
		if (fileHit) begin
			rdMux = {24'h000000, fileMem[fileIdx]};
		end else begin
			case (addr_q)
				`ARO_OFF_INSTR: rdMux = {8'h00, instr_q};
				`ARO_OFF_ACC:   rdMux = {24'h000000, acc_q};
				`ARO_OFF_STAT:  rdMux = {24'h000000, ~idle, 4'h0,
					flagZ_q, flagDc_q, flagC_q};
				`ARO_OFF_PTR0:  rdMux = {16'h0000, ptr0_q};
				`ARO_OFF_PTR1:  rdMux = {16'h0000, ptr1_q};
				`ARO_OFF_PC:    rdMux = {17'h00000, pc_q};
				`ARO_OFF_INTC:  rdMux = {24'h000000, intc_q};
				`ARO_OFF_STACK: rdMux = {13'h0000, sp_q, stackHead};
				default:        rdMux = 32'h00000000;
			endcase
		end
	end

	always @(posedge core_clk) begin
		if (rst) begin
			hrdata <= 32'h00000000;
		end else if (rdPend_q) begin
			hrdata <= rdMux;
		end
	end

endmodule // aro_core

`default_nettype wire

//--- tb/aro_core_props.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////
// Bus-side checks on the core's ports
module aro_core_props (
	input wire logic        core_clk,
	input wire logic        rst,
	input wire logic        hsel,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic [31:0] hrdata,
	input wire logic        hresp
);
	wire logic rdTake;
	wire logic wrTake;
	// Accepted address phases
	assign rdTake = hsel && htrans[1] && hready && !hwrite;
	assign wrTake = hsel && htrans[1] && hready && hwrite;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	resp_okay_a: assert property (hresp == 1'b0)
		else $error("error response seen");
	read_wait_a: assert property (rdTake |=> !hreadyout)
		else $error("read data phase without wait");
	read_done_a: assert property (rdTake |=> ##1 hreadyout)
		else $error("read wait longer than one cycle");
	write_nowait_a: assert property (wrTake |=> hreadyout)
		else $error("write data phase stalled");
	wait_cause_a: assert property (!hreadyout |-> $past(rdTake))
		else $error("wait state without a read");
	wait_single_a: assert property (!hreadyout |=> hreadyout)
		else $error("two wait cycles in a row");
	// Read data may only move as a read wait ends
	data_hold_a: assert property (!$stable(hrdata) |-> !$past(hreadyout))
		else $error("read data moved outside a read");
	reset_clear_a: assert property (disable iff (1'b0)
		rst |=> hreadyout && hrdata == 32'h0)
		else $error("bus outputs not cleared by reset");
	cover property (rdTake);
	cover property (wrTake);
	cover property (wrTake ##2 rdTake);
endmodule // aro_core_props
`default_nettype wire

//--- tb/aro_core_bench.sv
`timescale 1ns/1ps
`include "aro_defs.vh"
`default_nettype none
////////////////////////////////////////
module aro_core_bench;
	logic        core_clk = 1'b0;
	logic        rst      = 1'b1;
	logic        hsel     = 1'b0;
	logic [31:0] haddr    = 32'h0;
	logic [1:0]  htrans   = 2'h0;
	logic        hwrite   = 1'b0;
	logic [31:0] hwdata   = 32'h0;
	wire         hready;
	wire  [31:0] hrdata;
	wire         hresp;
	int          nMismatch = 0;
	int          testsRun  = 0;

	// Single slave, so its ready is the bus ready
	aro_core dut (
		.core_clk  (core_clk),
		.rst       (rst),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (3'h2),
		.hwdata    (hwdata),
		.hready    (hready),
		.hreadyout (hready),
		.hrdata    (hrdata),
		.hresp     (hresp)
	);

	// 25 MHz core clock
	always #20 core_clk = ~core_clk;

	////////////////////////////////////////
	// Verdict and end of run
	task automatic tally_and_finish();
		$display("Checks %0d, mismatches %0d", testsRun, nMismatch);
		if (nMismatch == 0 && testsRun > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Bounded wait so a stuck slave cannot hang the run
	task automatic wait_ready();
		int k;
		k = 0;
		@(posedge core_clk);
		while (hready !== 1'b1 && k < 50) begin
			@(posedge core_clk);
			k++;
		end
		// A ready that arrives on the last try still counts as an answer
		if (hready !== 1'b1) begin
			nMismatch++;
			tally_and_finish();
		end
	endtask

	// Address phase held until ready, then the data phase
	task automatic bus_op(input logic [11:0] a, input logic w,
		input logic [31:0] d, output logic [31:0] q);
		hsel   <= 1'b1;
		haddr  <= {20'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		wait_ready();
		htrans <= 2'h0;
		hwdata <= d;
		wait_ready();
		q = hrdata;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus_op(a, 1'b1, d, q);
	endtask

	// Read a word and compare it
	task automatic rchk(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus_op(a, 1'b0, 32'h0, q);
		testsRun++;
		if (q !== e) begin
			nMismatch++;
			$display("MISMATCH at %0t: exp %h got %h", $time, e, q);
		end
	endtask

	// Issue one instruction; two idle cycles cover even a return
	task automatic exe(input logic [3:0] op, input logic p,
		input logic d, input logic [6:0] f, input logic [7:0] k);
		wr(`ARO_OFF_INSTR, {8'h00, op, 3'b000, p, d, f, k});
		repeat (2) @(posedge core_clk);
	endtask

	function automatic logic [11:0] fad(input logic [6:0] i);
		fad = 12'h200 + {3'b000, i, 2'b00};
	endfunction

	////////////////////////////////////////
	initial begin
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		// Reset state and an unmapped word
		rchk(`ARO_OFF_STAT, 32'h0);
		rchk(`ARO_OFF_PTR1, 32'h0);
		rchk(`ARO_OFF_INTC, 32'h0);
		wr(12'h100, 32'hffff_ffff);
		rchk(12'h100, 32'h0);
		// Literal add with half carry, then wrap to zero
		wr(`ARO_OFF_ACC, 32'h0f);
		exe(`ARO_OP_ADDLIT, 1'b0, 1'b0, 7'd0, 8'h01);
		rchk(`ARO_OFF_ACC, 32'h10);
		rchk(`ARO_OFF_STAT, 32'h02);
		exe(`ARO_OP_ADDLIT, 1'b0, 1'b0, 7'd0, 8'hf0);
		rchk(`ARO_OFF_STAT, 32'h05);
		// Literal AND clears zero, keeps carry
		wr(`ARO_OFF_ACC, 32'hf3);
		exe(`ARO_OP_ANDLIT, 1'b0, 1'b0, 7'd0, 8'h0f);
		rchk(`ARO_OFF_ACC, 32'h03);
		rchk(`ARO_OFF_STAT, 32'h01);
		// File AND back into the file
		wr(fad(7'd5), 32'h3c);
		wr(`ARO_OFF_ACC, 32'h0f);
		exe(`ARO_OP_ANDF, 1'b0, 1'b1, 7'd5, 8'h00);
		rchk(fad(7'd5), 32'h0c);
		rchk(`ARO_OFF_ACC, 32'h0f);
		// File add into the accumulator
		exe(`ARO_OP_ADDF, 1'b0, 1'b0, 7'd5, 8'h00);
		rchk(`ARO_OFF_ACC, 32'h1b);
		rchk(`ARO_OFF_STAT, 32'h02);
		rchk(fad(7'd5), 32'h0c);
		// Add with carry in, wrapping to zero
		wr(`ARO_OFF_STAT, 32'h01);
		wr(`ARO_OFF_ACC, 32'h80);
		wr(fad(7'd6), 32'h7f);
		exe(`ARO_OP_ADDCF, 1'b0, 1'b1, 7'd6, 8'h00);
		rchk(fad(7'd6), 32'h00);
		rchk(`ARO_OFF_STAT, 32'h07);
		// Arithmetic shift keeps the sign bit
		wr(fad(7'd7), 32'h81);
		exe(`ARO_OP_ASR, 1'b0, 1'b0, 7'd7, 8'h00);
		rchk(`ARO_OFF_ACC, 32'hc0);
		rchk(`ARO_OFF_STAT, 32'h03);
		// Rotate through carry
		wr(fad(7'd8), 32'h66);
		exe(`ARO_OP_RLC, 1'b0, 1'b1, 7'd8, 8'h00);
		rchk(fad(7'd8), 32'hcd);
		rchk(`ARO_OFF_STAT, 32'h02);
		// Pointer offsets at both ends of the range
		wr(`ARO_OFF_STAT, 32'h07);
		wr(`ARO_OFF_PTR0, 32'hffff);
		wr(`ARO_OFF_PTR1, 32'h0005);
		exe(`ARO_OP_PTRADD, 1'b0, 1'b0, 7'd0, 8'h01);
		rchk(`ARO_OFF_PTR0, 32'h0000);
		exe(`ARO_OP_PTRADD, 1'b1, 1'b0, 7'd0, 8'h20);
		rchk(`ARO_OFF_PTR1, 32'hffe5);
		exe(`ARO_OP_PTRADD, 1'b0, 1'b0, 7'd0, 8'h1f);
		rchk(`ARO_OFF_PTR0, 32'h001f);
		rchk(`ARO_OFF_STAT, 32'h07);
		// Three returns unwind three pushes
		wr(`ARO_OFF_STACK, 32'h1234);
		wr(`ARO_OFF_STACK, 32'h2345);
		wr(`ARO_OFF_STACK, 32'h0456);
		exe(`ARO_OP_RET, 1'b0, 1'b0, 7'd0, 8'h00);
		rchk(`ARO_OFF_PC, 32'h0456);
		exe(`ARO_OP_RETLIT, 1'b0, 1'b0, 7'd0, 8'h5a);
		rchk(`ARO_OFF_ACC, 32'h5a);
		rchk(`ARO_OFF_PC, 32'h2345);
		exe(`ARO_OP_RETI, 1'b0, 1'b0, 7'd0, 8'h00);
		rchk(`ARO_OFF_PC, 32'h1234);
		rchk(`ARO_OFF_INTC, 32'h80);
		rchk(`ARO_OFF_STAT, 32'h07);
		// Read straight after issue: a return is still busy
		wr(`ARO_OFF_STACK, 32'h0777);
		wr(`ARO_OFF_INSTR, {8'h00, `ARO_OP_RET, 20'h00000});
		rchk(`ARO_OFF_STAT, 32'h87);
		rchk(`ARO_OFF_PC, 32'h0777);
		// An ALU op is done by the very next read
		wr(`ARO_OFF_INSTR, {8'h00, `ARO_OP_ANDLIT, 12'h000, 8'hff});
		rchk(`ARO_OFF_STAT, 32'h03);
		rchk(`ARO_OFF_ACC, 32'h5a);
		tally_and_finish();
	end
endmodule // aro_core_bench

bind aro_core aro_core_props chk (
	.core_clk(core_clk), .rst(rst), .hsel(hsel), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
	.hrdata(hrdata), .hresp(hresp)
);
`default_nettype wire
